// ---- logic/cmmd_pkg.sv ----
// Behaviour
// - One 64K code space, shared with data by instruction type
// - Flash code store spans 0x0000 to 0x3FFF
// - Code 0x3E00 to 0x3FFF reserved, never user-written
// - Extra 128-byte flash block at 0x8000-0x807F
// - Code writes only by external move with enable
// - 256 bytes of internal RAM, 0x00 to 0xFF
// - Lower 128 bytes reached directly and indirectly
// - Above 0x7F: direct to registers, indirect upper RAM
// - 0x00-0x1F are four banks, status bits 3-4
// - One bank active; register operands use it only
// - Indirect address taken from index register zero/one
// - Bytes 0x20-0x2F give bit addresses 0x00-0x7F
// - Bit or byte access chosen by operand type
// - Stack anywhere in RAM, pointer at 0x81
// - Push writes pointer plus one, then increments it
// - Pointer resets to 0x07, first push at 0x08
// - 32-bit stack record, one or two bits per op
// - Stack overflow and underflow reported to debug
// - Only registers ending 0x0/0x8 are bit-addressable
// - 1024 bytes external RAM, external move only
package cmmd_pkg;

    // ------------------------------------------------------------------
    // Address map constants.
    // ------------------------------------------------------------------
    localparam logic [15:0] MAIN_TOP    = 16'h3fff;
    localparam logic [15:0] RSVD_BASE   = 16'h3e00;
    localparam logic [15:0] XBLK_BASE   = 16'h8000;
    localparam logic [15:0] XBLK_TOP    = 16'h807f;
    localparam logic [7:0]  LO_TOP      = 8'h7f;
    localparam logic [7:0]  BIT_BASE    = 8'h20;
    localparam logic [7:0]  STKPTR_ADDR    = 8'h81;
    localparam logic [7:0]  STATUS_ADDR    = 8'hd0;
    localparam logic [7:0]  STORE_CTL_ADDR = 8'h8f;
    localparam logic [7:0]  STKPTR_RESET   = 8'h07;
    localparam int          BANK_LSB    = 3;
    localparam int          PS_WE_BIT   = 0;
    localparam int          HALF_BYTES  = 128;
    localparam int          XRAM_BYTES  = 1024;
    localparam int          REC_W       = 32;
    localparam logic [5:0]  REC_FULL    = 6'h20;

    // ------------------------------------------------------------------
    // Access modes, stack operations and code regions.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_REG   = 3'b000,
        MODE_DBYTE = 3'b001,
        MODE_DBIT  = 3'b010,
        MODE_IND   = 3'b011,
        MODE_CODE  = 3'b100,
        MODE_XMOVE = 3'b101
    } cmmd_mode_t;

    typedef enum logic [2:0] {
        STK_NONE = 3'b000,
        STK_PUSH = 3'b001,
        STK_POP  = 3'b010,
        STK_CALL = 3'b011,
        STK_RET  = 3'b100
    } cmmd_stk_op_t;

    typedef enum logic [1:0] {
        REGION_USER = 2'b00,
        REGION_RSVD = 2'b01,
        REGION_XBLK = 2'b10,
        REGION_NONE = 2'b11
    } cmmd_region_t;

    // ------------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        cmmd_mode_t  mode;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cmmd_req_t;

    typedef struct packed {
        cmmd_stk_op_t op;
        logic [15:0]  data;
    } cmmd_stk_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } cmmd_rsp_t;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       bit_op;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmmd_sfr_t;

    typedef struct packed {
        logic         valid;
        logic         wr;
        cmmd_region_t region;
        logic [15:0]  addr;
        logic [7:0]   wdata;
    } cmmd_prog_t;

    typedef struct packed {
        logic [REC_W-1:0] bits;
        logic [5:0]       depth;
        logic             ovf;
        logic             unf;
    } cmmd_rec_t;

    typedef struct packed {
        logic [HALF_BYTES-1:0][7:0] lo_ram;
        logic [HALF_BYTES-1:0][7:0] hi_ram;
        logic [XRAM_BYTES-1:0][7:0] xram;
        logic [7:0]                 sp;
        logic [7:0]                 program_status_word;
        logic [7:0]                 program_store_control;
        cmmd_rec_t                  rec;
        cmmd_rsp_t                  rsp;
    } cmmd_state_t;

    localparam cmmd_state_t STATE_RST = '{sp: STKPTR_RESET, default: '0};

endpackage : cmmd_pkg

// ---- logic/cmmd_core.sv ----
`timescale 1ns/1ns
module cmmd_core
    import cmmd_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire cmmd_req_t     req_i,
    input  wire cmmd_stk_req_t stk_i,
    input  wire logic [7:0]    sfr_rdata_i,
    input  wire logic [7:0]    prog_rdata_i,
    output cmmd_rsp_t          rsp_o,
    output cmmd_sfr_t          sfr_o,
    output cmmd_prog_t         prog_o,
    output logic [7:0]         sp_o,
    output logic [1:0]         bank_o,
    output logic               ovf_o,
    output logic               unf_o
);

    // ------------------------------------------------------------------
    // State and helper functions.
    // ------------------------------------------------------------------
    cmmd_state_t s_reg;
    cmmd_state_t s_next;

    // Classifies a code address; the 64K space is a bare 16-bit address.
    function automatic cmmd_region_t prog_region(input logic [15:0] a);
        if (a < RSVD_BASE) begin
            prog_region = REGION_USER;
        end else if (a <= MAIN_TOP) begin
            prog_region = REGION_RSVD;
        end else if (a >= XBLK_BASE && a <= XBLK_TOP) begin
            prog_region = REGION_XBLK;
        end else begin
            prog_region = REGION_NONE;
        end
    endfunction : prog_region

    // Indirect space read: upper half is the separate RAM, not registers.
    function automatic logic [7:0] ram_rd(input cmmd_state_t s,
                                          input logic [7:0]  a);
        ram_rd = a[7] ? s.hi_ram[a[6:0]] : s.lo_ram[a[6:0]];
    endfunction : ram_rd

    function automatic cmmd_state_t ram_wr(input cmmd_state_t s,
                                           input logic [7:0]  a,
                                           input logic [7:0]  d);
        ram_wr = s;
        if (a[7]) begin
            ram_wr.hi_ram[a[6:0]] = d;
        end else begin
            ram_wr.lo_ram[a[6:0]] = d;
        end
    endfunction : ram_wr

    // Stack record shift; depth saturates so the flags stay meaningful.
    function automatic cmmd_rec_t rec_upd(input cmmd_rec_t r,
                                          input logic      push,
                                          input logic      two);
        rec_upd = r;
        if (push && two) begin
            rec_upd.bits = {r.bits[REC_W-3:0], 2'b11};
            rec_upd.ovf  = (r.depth > REC_FULL - 6'h02);
            rec_upd.depth = rec_upd.ovf ? REC_FULL : r.depth + 6'h02;
        end else if (push) begin
            rec_upd.bits = {r.bits[REC_W-2:0], 1'b0};
            rec_upd.ovf  = (r.depth == REC_FULL);
            rec_upd.depth = rec_upd.ovf ? REC_FULL : r.depth + 6'h01;
        end else if (two) begin
            rec_upd.bits = {2'b00, r.bits[REC_W-1:2]};
            rec_upd.unf  = (r.depth < 6'h02);
            rec_upd.depth = rec_upd.unf ? 6'h00 : r.depth - 6'h02;
        end else begin
            rec_upd.bits = {1'b0, r.bits[REC_W-1:1]};
            rec_upd.unf  = (r.depth == 6'h00);
            rec_upd.depth = rec_upd.unf ? 6'h00 : r.depth - 6'h01;
        end
    endfunction : rec_upd

    // ------------------------------------------------------------------
    // Decode and update.
    // ------------------------------------------------------------------
    logic [1:0] bank;
    logic [7:0] a8;
    logic [7:0] ptr;
    logic [7:0] tgt;
    logic [7:0] byte_v;

    // Stack operations win over an access offered in the same cycle.
    always_comb begin
        s_next         = s_reg;
        s_next.rsp     = '0;
        s_next.rec.ovf = 1'b0;
        s_next.rec.unf = 1'b0;
        sfr_o          = '0;
        prog_o         = '0;
        bank           = s_reg.program_status_word[BANK_LSB+1:BANK_LSB];
        a8             = req_i.addr[7:0];
        ptr            = s_reg.lo_ram[{2'b00, bank, 2'b00, a8[0]}];
        tgt            = 8'h00;
        byte_v         = 8'h00;
        if (stk_i.op != STK_NONE) begin
            s_next.rsp.valid = 1'b1;
            unique case (stk_i.op)
                STK_PUSH: begin
                    tgt    = s_reg.sp + 8'h01;
                    s_next = ram_wr(s_next, tgt, stk_i.data[7:0]);
                    s_next.sp  = tgt;
                    s_next.rec = rec_upd(s_reg.rec, 1'b1, 1'b0);
                end
                STK_CALL: begin
                    s_next = ram_wr(s_next, s_reg.sp + 8'h01,
                                    stk_i.data[7:0]);
                    s_next = ram_wr(s_next, s_reg.sp + 8'h02,
                                    stk_i.data[15:8]);
                    s_next.sp  = s_reg.sp + 8'h02;
                    s_next.rec = rec_upd(s_reg.rec, 1'b1, 1'b1);
                end
                STK_POP: begin
                    s_next.rsp.data = {8'h00, ram_rd(s_reg, s_reg.sp)};
                    s_next.sp  = s_reg.sp - 8'h01;
                    s_next.rec = rec_upd(s_reg.rec, 1'b0, 1'b0);
                end
                STK_RET: begin
                    s_next.rsp.data = {ram_rd(s_reg, s_reg.sp),
                                       ram_rd(s_reg, s_reg.sp - 8'h01)};
                    s_next.sp  = s_reg.sp - 8'h02;
                    s_next.rec = rec_upd(s_reg.rec, 1'b0, 1'b1);
                end
                default: s_next.rsp.valid = 1'b0;
            endcase
        end else if (req_i.valid) begin
            s_next.rsp.valid = 1'b1;
            unique case (req_i.mode)
                MODE_REG: begin
                    tgt = {3'b000, bank, a8[2:0]};
                    s_next.rsp.data = {8'h00, s_reg.lo_ram[tgt[6:0]]};
                    if (req_i.wr) begin
                        s_next.lo_ram[tgt[6:0]] = req_i.wdata;
                    end
                end
                MODE_IND: begin
                    s_next.rsp.data = {8'h00, ram_rd(s_reg, ptr)};
                    if (req_i.wr) begin
                        s_next = ram_wr(s_next, ptr, req_i.wdata);
                    end
                end
                MODE_DBYTE: begin
                    if (a8 <= LO_TOP) begin
                        s_next.rsp.data = {8'h00, s_reg.lo_ram[a8[6:0]]};
                        if (req_i.wr) begin
                            s_next.lo_ram[a8[6:0]] = req_i.wdata;
                        end
                    end else if (a8 == STKPTR_ADDR) begin
                        s_next.rsp.data = {8'h00, s_reg.sp};
                        if (req_i.wr) begin
                            s_next.sp = req_i.wdata;
                            // A write of pointer plus or minus one keeps
                            // the record in step with software pushes.
                            if (req_i.wdata == s_reg.sp + 8'h01) begin
                                s_next.rec = rec_upd(s_reg.rec, 1'b1,
                                                     1'b0);
                            end else if (req_i.wdata == s_reg.sp - 8'h01)
                            begin
                                s_next.rec = rec_upd(s_reg.rec, 1'b0,
                                                     1'b0);
                            end
                        end
                    end else if (a8 == STATUS_ADDR) begin
                        s_next.rsp.data = {8'h00, s_reg.program_status_word};
                        if (req_i.wr) begin
                            s_next.program_status_word = req_i.wdata;
                        end
                    end else if (a8 == STORE_CTL_ADDR) begin
                        s_next.rsp.data = {8'h00, s_reg.program_store_control};
                        if (req_i.wr) begin
                            s_next.program_store_control = req_i.wdata;
                        end
                    end else begin
                        // Other peripherals answer combinationally; an
                        // unoccupied address returns whatever they drive.
                        sfr_o.valid = 1'b1;
                        sfr_o.wr    = req_i.wr;
                        sfr_o.addr  = a8;
                        sfr_o.wdata = req_i.wdata;
                        s_next.rsp.data = {8'h00, sfr_rdata_i};
                    end
                end
                MODE_DBIT: begin
                    // Bit mode is chosen by the operand, never the address.
                    if (!a8[7]) begin
                        tgt = BIT_BASE + {4'h0, a8[6:3]};
                        byte_v = s_reg.lo_ram[tgt[6:0]];
                        byte_v[a8[2:0]] = req_i.wdata[0];
                        s_next.rsp.data = {15'h0000,
                                           s_reg.lo_ram[tgt[6:0]][a8[2:0]]};
                        if (req_i.wr) begin
                            s_next.lo_ram[tgt[6:0]] = byte_v;
                        end
                    end else begin
                        tgt = {a8[7:3], 3'b000};
                        if (tgt == STATUS_ADDR) begin
                            byte_v = s_reg.program_status_word;
                            byte_v[a8[2:0]] = req_i.wdata[0];
                            s_next.rsp.data = {15'h0000,
                                               s_reg.program_status_word[a8[2:0]]};
                            if (req_i.wr) begin
                                s_next.program_status_word = byte_v;
                            end
                        end else begin
                            // Base addresses end in 0x0 or 0x8 only.
                            sfr_o.valid   = 1'b1;
                            sfr_o.wr      = req_i.wr;
                            sfr_o.bit_op  = 1'b1;
                            sfr_o.bit_sel = a8[2:0];
                            sfr_o.addr    = tgt;
                            sfr_o.wdata   = {7'h00, req_i.wdata[0]};
                            s_next.rsp.data = {15'h0000,
                                               sfr_rdata_i[a8[2:0]]};
                        end
                    end
                end
                MODE_CODE: begin
                    prog_o.valid  = 1'b1;
                    prog_o.addr   = req_i.addr;
                    prog_o.region = prog_region(req_i.addr);
                    s_next.rsp.data = {8'h00, prog_rdata_i};
                end
                MODE_XMOVE: begin
                    if (req_i.wr && s_reg.program_store_control[PS_WE_BIT]) begin
                        // The factory area and holes never see a write.
                        prog_o.region = prog_region(req_i.addr);
                        prog_o.valid  = (prog_o.region == REGION_USER) ||
                                        (prog_o.region == REGION_XBLK);
                        prog_o.wr     = prog_o.valid;
                        prog_o.addr   = req_i.addr;
                        prog_o.wdata  = req_i.wdata;
                    end else begin
                        s_next.rsp.data = {8'h00,
                                           s_reg.xram[req_i.addr[9:0]]};
                        if (req_i.wr) begin
                            s_next.xram[req_i.addr[9:0]] = req_i.wdata;
                        end
                    end
                end
                default: s_next.rsp.valid = 1'b0;
            endcase
        end
    end

    // Register the whole state; reset loads the pointer with 0x07.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign rsp_o  = s_reg.rsp;
    assign sp_o   = s_reg.sp;
    assign bank_o = s_reg.program_status_word[BANK_LSB+1:BANK_LSB];
    assign ovf_o  = s_reg.rec.ovf;
    assign unf_o  = s_reg.rec.unf;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_push;
        stk_i.op == STK_PUSH;
    endsequence

    sequence seq_req_only;
        stk_i.op == STK_NONE && req_i.valid;
    endsequence

    a_sp_reset_val: assert property (
        $rose(rst_n_i) |-> sp_o == STKPTR_RESET)
        else $error("Stack pointer not 0x07 after reset.");

    a_push_place: assert property (
        seq_push |=> sp_o == $past(sp_o) + 8'h01 &&
            (sp_o[7] ? s_reg.hi_ram[sp_o[6:0]] : s_reg.lo_ram[sp_o[6:0]])
            == $past(stk_i.data[7:0]))
        else $error("Push did not land at pointer plus one.");

    a_ret_pointer: assert property (
        stk_i.op == STK_RET |=> sp_o == $past(sp_o) - 8'h02 &&
            s_reg.rec.bits[REC_W-1:REC_W-2] == 2'b00)
        else $error("Return did not drop two.");

    a_call_record: assert property (
        stk_i.op == STK_CALL |=> s_reg.rec.bits[1:0] == 2'b11)
        else $error("Call did not shift in two record bits.");

    a_ovf_flag: assert property (
        seq_push ##0 s_reg.rec.depth == REC_FULL |=> ovf_o ##1 !ovf_o
            || $past(stk_i.op) inside {STK_PUSH, STK_CALL})
        else $error("Overflow not flagged for one cycle.");

    a_unf_flag: assert property (
        stk_i.op == STK_POP && s_reg.rec.depth == 6'h00 |=> unf_o)
        else $error("Underflow not flagged.");

    a_rsp_timing: assert property (
        seq_req_only |=> rsp_o.valid)
        else $error("Access not answered next cycle.");

    a_bank_write: assert property (
        seq_req_only ##0 req_i.mode == MODE_REG && req_i.wr |=>
            s_reg.lo_ram[{2'b00, $past(bank_o), $past(req_i.addr[2:0])}]
            == $past(req_i.wdata))
        else $error("Register write missed the selected bank.");

    a_prog_guard: assert property (
        prog_o.wr |-> s_reg.program_store_control[PS_WE_BIT] &&
            prog_o.region != REGION_RSVD && prog_o.region != REGION_NONE)
        else $error("Code write without enable or in reserved area.");

    a_direct_hi_sfr: assert property (
        seq_req_only ##0 req_i.mode == MODE_DBYTE && req_i.addr[7] |=>
            s_reg.hi_ram == $past(s_reg.hi_ram))
        else $error("Direct access above 0x7F touched upper RAM.");

    a_bit_map: assert property (
        seq_req_only ##0 req_i.mode == MODE_DBIT && req_i.wr &&
            !req_i.addr[7] |=> s_reg.lo_ram[{3'b010,
            $past(req_i.addr[6:3])}][$past(req_i.addr[2:0])]
            == $past(req_i.wdata[0]))
        else $error("Bit write landed on the wrong byte or bit.");

endmodule : cmmd_core

// ---- bench/cmmd_far_model.sv ----
`timescale 1ns/1ns
module cmmd_far_model
    import cmmd_pkg::*;
(
    input  wire cmmd_sfr_t  sfr_i,
    input  wire cmmd_prog_t prog_i,
    output logic [7:0]      sfr_rdata_o,
    output logic [7:0]      prog_rdata_o
);
    // Outside registers and code store answer in the same cycle. The
    // value is derived from the address so that a wrong route shows up.
    assign sfr_rdata_o  = ~sfr_i.addr;
    assign prog_rdata_o = prog_i.addr[7:0] ^ 8'h5a;
endmodule : cmmd_far_model

// ---- bench/core_memory_map_decode_test.sv ----
`timescale 1ns/1ns
module core_memory_map_decode_test;
    import cmmd_pkg::*;
    logic          mclk_i;
    logic          rst_n_i;
    cmmd_req_t     req;
    cmmd_stk_req_t stk;
    logic [7:0]    sfr_rdata;
    logic [7:0]    prog_rdata;
    cmmd_rsp_t     rsp_o;
    cmmd_sfr_t     sfr_o;
    cmmd_prog_t    prog_o;
    cmmd_prog_t    last_prog;
    logic [7:0]    sp_o;
    logic [1:0]    bank_o;
    logic          ovf_o;
    logic          unf_o;
    logic [15:0]   q;
    logic [1:0]    flg;
    int            i;
    int            failures;
    int            samples_checked;

    cmmd_core cmmd_core_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_i(req), .stk_i(stk), .sfr_rdata_i(sfr_rdata),
        .prog_rdata_i(prog_rdata), .rsp_o(rsp_o), .sfr_o(sfr_o),
        .prog_o(prog_o), .sp_o(sp_o), .bank_o(bank_o), .ovf_o(ovf_o),
        .unf_o(unf_o));
    cmmd_far_model cmmd_far_model_inst (.sfr_i(sfr_o), .prog_i(prog_o),
        .sfr_rdata_o(sfr_rdata), .prog_rdata_o(prog_rdata));

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One access; entered just after an edge, answer sampled a cycle on.
    task automatic acc(input cmmd_mode_t m, input logic w,
                       input logic [15:0] a, input logic [7:0] d);
        req = '{valid: 1'b1, mode: m, wr: w, addr: a, wdata: d};
        #1 last_prog = prog_o;
        @(posedge mclk_i);
        #1 req.valid = 1'b0;
        chk("rsp valid", 16'h1, {15'h0, rsp_o.valid});
        q = rsp_o.data;
        // One idle edge so the next call never redrives in this step.
        @(posedge mclk_i);
        #1;
    endtask : acc

    task automatic stack(input cmmd_stk_op_t o, input logic [15:0] d);
        stk = '{op: o, data: d};
        @(posedge mclk_i);
        #1 stk.op = STK_NONE;
        chk("stack rsp valid", 16'h1, {15'h0, rsp_o.valid});
        q = rsp_o.data;
        flg = {ovf_o, unf_o};
        @(posedge mclk_i);
        #1;
    endtask : stack

    task automatic end_sim;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // Scenarios, run in order on one reset.
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        req = '0;
        stk = '{op: STK_NONE, data: 16'h0};
        repeat (2) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        chk("sp reset", 16'h07, {8'h0, sp_o});
        chk("bank reset", 16'h0, {14'h0, bank_o});
        // Push lands at 0x08, then pop, then pop from an empty record.
        stack(STK_PUSH, 16'h0033);
        chk("sp push", 16'h08, {8'h0, sp_o});
        acc(MODE_DBYTE, 1'b0, 16'h0008, 8'h0);
        chk("push byte", 16'h33, q);
        stack(STK_POP, 16'h0);
        chk("pop byte", 16'h33, {8'h0, q[7:0]});
        chk("no underflow", 16'h0, {15'h0, flg[0]});
        stack(STK_POP, 16'h0);
        chk("underflow", 16'h1, {15'h0, flg[0]});
        // Bank three through the status word, register two of it.
        acc(MODE_DBYTE, 1'b1, {8'h0, STATUS_ADDR}, 8'h18);
        chk("bank", 16'h3, {14'h0, bank_o});
        acc(MODE_REG, 1'b1, 16'h0002, 8'ha5);
        acc(MODE_DBYTE, 1'b0, 16'h001a, 8'h0);
        chk("bank reg", 16'ha5, q);
        acc(MODE_DBYTE, 1'b0, 16'h0002, 8'h0);
        chk("bank0 untouched", 16'h00, q);
        // Index register zero points above 0x7f: upper RAM, not SPECIAL_FUNCTION_REGISTER.
        acc(MODE_REG, 1'b1, 16'h0000, 8'h90);
        acc(MODE_IND, 1'b1, 16'h0000, 8'h77);
        acc(MODE_IND, 1'b0, 16'h0000, 8'h0);
        chk("upper ram", 16'h77, q);
        acc(MODE_DBYTE, 1'b0, 16'h0090, 8'h0);
        chk("direct sfr", 16'h6f, q);
        // Bit 0x13 is bit three of byte 0x22.
        acc(MODE_DBIT, 1'b1, 16'h0013, 8'h01);
        acc(MODE_DBYTE, 1'b0, 16'h0022, 8'h0);
        chk("bit write", 16'h08, q);
        acc(MODE_DBIT, 1'b0, 16'h0013, 8'hff);
        chk("bit read", 16'h01, {15'h0, q[0]});
        // Code regions, then store writes with the enable clear and set.
        acc(MODE_CODE, 1'b0, 16'h0000, 8'h0);
        chk("user region", 16'h0, {14'h0, last_prog.region});
        acc(MODE_CODE, 1'b0, 16'h3e00, 8'h0);
        chk("rsvd region", 16'h1, {14'h0, last_prog.region});
        acc(MODE_CODE, 1'b0, 16'h807f, 8'h0);
        chk("xblk region", 16'h2, {14'h0, last_prog.region});
        chk("code read", 16'h25, q);
        acc(MODE_XMOVE, 1'b1, 16'h0100, 8'h11);
        chk("no code write", 16'h0, {15'h0, last_prog.valid});
        acc(MODE_DBYTE, 1'b1, {8'h0, STORE_CTL_ADDR}, 8'h01);
        acc(MODE_XMOVE, 1'b1, 16'h0100, 8'h11);
        chk("code write", 16'h1, {15'h0, last_prog.wr});
        acc(MODE_XMOVE, 1'b1, 16'h3e00, 8'h11);
        chk("rsvd blocked", 16'h0, {15'h0, last_prog.valid});
        // Call then return restore the pointer and give the word back.
        stack(STK_CALL, 16'hbeef);
        chk("sp call", 16'h08, {8'h0, sp_o});
        stack(STK_RET, 16'h0);
        chk("ret word", 16'hbeef, q);
        chk("sp ret", 16'h06, {8'h0, sp_o});
        // Thirty-three pushes from an empty record overflow it once.
        for (i = 0; i < 33; i++) begin
            stack(STK_PUSH, 16'h0);
            chk("ovf", {15'h0, i == 32}, {15'h0, flg[1]});
        end
        // Bit 0x83 is bit three of the outside register at 0x80.
        acc(MODE_DBIT, 1'b0, 16'h0083, 8'h0);
        chk("outside bit", 16'h01, {15'h0, q[0]});
        end_sim();
    end
endmodule : core_memory_map_decode_test
